// ### common/fmf_pkg.sv
// Package of constants and carrier types for the flash and memory map front end
package fmf_pkg;

  // ***************************************************************
  // Flash geometry
  // ***************************************************************
  localparam int          FMF_BANK_BYTES      = 32'h0008_0000;
  localparam int          FMF_SECT_FULL       = 22;
  localparam int          FMF_SECT_HALF       = 14;
  localparam logic [31:0] FMF_BANK1_BASE      = 32'h0008_0000;
  localparam logic [31:0] FMF_BANK2_BASE      = 32'h0010_0000;
  localparam logic [31:0] FMF_BANK3_BASE      = 32'h0018_0000;
  localparam logic [31:0] FMF_FLASH_END_FULL  = 32'h001F_FFFF;
  localparam logic [31:0] FMF_FLASH_END_HALF  = 32'h000F_FFFF;
  // Bank 0 sector start offsets, sectors 1..9
  localparam logic [31:0] FMF_B0_S1           = 32'h0000_8000;
  localparam logic [31:0] FMF_B0_S2           = 32'h0001_0000;
  localparam logic [31:0] FMF_B0_S3           = 32'h0001_8000;
  localparam logic [31:0] FMF_B0_S4           = 32'h0001_A000;
  localparam logic [31:0] FMF_B0_S5           = 32'h0001_C000;
  localparam logic [31:0] FMF_B0_S6           = 32'h0002_0000;
  localparam logic [31:0] FMF_B0_S7           = 32'h0003_0000;
  localparam logic [31:0] FMF_B0_S8           = 32'h0004_0000;
  localparam logic [31:0] FMF_B0_S9           = 32'h0006_0000;
  localparam int          FMF_SECT128_SHIFT   = 17;

  // ***************************************************************
  // Other frames
  // ***************************************************************
  localparam logic [31:0] FMF_RAM_BASE        = 32'h0800_0000;
  localparam logic [31:0] FMF_RAM_BYTES_BIG   = 32'h0002_8000;
  localparam logic [31:0] FMF_RAM_BYTES_SMALL = 32'h0002_0000;
  localparam logic [31:0] FMF_OVL_BASE        = 32'h6000_0000;
  localparam logic [31:0] FMF_OVL_BYTES       = 32'h0040_0000;
  localparam logic [31:0] FMF_CS0_BASE        = 32'h6000_0000;
  localparam logic [31:0] FMF_CS_BASE_STEP    = 32'h0800_0000;
  localparam logic [31:0] FMF_CS_LIM_16       = 32'h0200_0000;
  localparam logic [31:0] FMF_CS_LIM_8        = 32'h0100_0000;
  localparam logic [31:0] FMF_CHK_BASE        = 32'hFE00_0000;
  localparam logic [31:0] FMF_CHK_END         = 32'hFEFF_FFFF;
  localparam logic [31:0] FMF_FWR_BASE        = 32'hFFF8_7000;
  localparam logic [31:0] FMF_FWR_END         = 32'hFFF8_7FFF;
  localparam logic [31:0] FMF_SYS_BASE        = 32'hFFFF_FF00;
  localparam logic [2:0]  FMF_RDCTL_RST       = 3'h0;
  localparam logic        FMF_EXT16_RST       = 1'h1;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [3:0] {
    FMF_T_NONE  = 4'h0,
    FMF_T_FLASH = 4'h1,
    FMF_T_RAM   = 4'h2,
    FMF_T_EXT   = 4'h3,
    FMF_T_CHK   = 4'h4,
    FMF_T_FWR   = 4'h5,
    FMF_T_SYS   = 4'h6
  } fmf_target_t;

  typedef enum logic [1:0] {
    FMF_OP_READ  = 2'h0,
    FMF_OP_PROG  = 2'h1,
    FMF_OP_ERASE = 2'h2
  } fmf_op_t;

  typedef struct packed {
    logic [31:0] addr;
    fmf_op_t     op;
    logic [1:0]  size;   // 0 byte, 1 half, 2 word, 3 doubleword
  } fmf_req_t;

  typedef struct packed {
    fmf_target_t target;
    logic [1:0]  bank;
    logic [4:0]  sector;
    logic [3:0]  local_sector;
    logic [31:0] xaddr;
    logic [1:0]  chip_sel;
    logic        err;
  } fmf_rsp_t;

endpackage : fmf_pkg

// ### dv/fmf_flash_model.sv
// Flash array model feeding 128-bit lines to the front end
`timescale 1ns/1ps
module fmf_flash_model (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         send,
  input  wire logic [127:0] send_line,
  input  wire logic         flash_line_ready,
  output logic              flash_line_valid,
  output logic      [127:0] flash_line
);
  // A line is held until accepted; once gone the bus toggles so stale data never matches
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flash_line_valid <= 1'b0;
      flash_line       <= '1;
    end else if (!flash_line_valid || flash_line_ready) begin
      flash_line_valid <= send;
      flash_line       <= send ? send_line : ~flash_line;
    end
  end
endmodule : fmf_flash_model

// ### dv/fmf_frontend_assertions.sv
// Port checker of the flash and memory map front end
`timescale 1ns/1ps
module fmf_frontend_assertions
  import fmf_pkg::*;
#(
  parameter bit FULL_FLASH = 1'b1
) (
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic              req_valid,
  input wire fmf_pkg::fmf_req_t req,
  input wire logic              rsp_valid,
  input wire fmf_pkg::fmf_rsp_t rsp,
  input wire logic              cfg_we,
  input wire logic [2:0]        cfg_read_ctl,
  input wire logic              cfg_ext16,
  input wire logic [2:0]        flash_read_control_field,
  input wire logic              ext_width16,
  input wire logic              flash_line_valid,
  input wire logic [127:0]      flash_line,
  input wire logic              flash_line_ready,
  input wire logic              beat_valid,
  input wire logic [63:0]       beat_data
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  a_rsp_taken: assert property (req_valid |=> rsp_valid)
    else $error("response late");
  a_rsp_pulse: assert property (!req_valid |=> !rsp_valid)
    else $error("response without request");
  a_ctl_load: assert property (cfg_we |=> flash_read_control_field == $past(cfg_read_ctl))
    else $error("read control not loaded");
  a_cfg_hold: assert property (!cfg_we |=> $stable(flash_read_control_field) && $stable(ext_width16))
    else $error("config moved");
  a_ext_load: assert property (cfg_we |=> ext_width16 == $past(cfg_ext16))
    else $error("width not loaded");
  a_beat_low: assert property (flash_line_valid && flash_line_ready |=>
    beat_valid && beat_data == $past(flash_line[63:0]))
    else $error("low beat wrong");
  a_beat_high: assert property (flash_line_valid && flash_line_ready && flash_read_control_field != 3'h0
    && !cfg_we |=> !flash_line_ready ##1 beat_valid && beat_data == $past(flash_line[127:64], 2))
    else $error("high beat wrong");
  a_prog_size: assert property (req_valid && req.op == FMF_OP_PROG && req.addr <= FMF_FLASH_END_FULL
    && (req.size == 2'h0 || req.size == 2'h3) |=> rsp.err)
    else $error("bad program size accepted");
  a_unpop_err: assert property (!FULL_FLASH && req_valid && req.addr > FMF_FLASH_END_HALF
    && req.addr <= FMF_FLASH_END_FULL |=> rsp.err)
    else $error("absent bank accepted");
  a_cs_limit: assert property (req_valid && req.addr[31:29] == 3'h3 && !cfg_we
    && req.addr[26:0] >= (ext_width16 ? FMF_CS_LIM_16 : FMF_CS_LIM_8) |=> rsp.err)
    else $error("chip select range");
  a_ovl_map: assert property (req_valid && req.addr[31:22] == FMF_OVL_BASE[31:22] |=>
    rsp.target == FMF_T_EXT && rsp.chip_sel == 2'h0 && rsp.xaddr == $past(req.addr))
    else $error("overlay map");
  c_two_beats: cover property (beat_valid ##1 beat_valid);
  c_err: cover property (rsp_valid && rsp.err);
  c_pipe_on: cover property (cfg_we ##1 flash_read_control_field != 3'h0);
endmodule : fmf_frontend_assertions

bind fmf_frontend fmf_frontend_assertions #(.FULL_FLASH(FULL_FLASH)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
  .rsp(rsp), .cfg_we(cfg_we), .cfg_read_ctl(cfg_read_ctl), .cfg_ext16(cfg_ext16),
  .flash_read_control_field(flash_read_control_field), .ext_width16(ext_width16),
  .flash_line_valid(flash_line_valid), .flash_line(flash_line),
  .flash_line_ready(flash_line_ready), .beat_valid(beat_valid), .beat_data(beat_data));

// ### dv/fmf_frontend_bench.sv
// Testbench of the flash and memory map front end
`timescale 1ns/1ps
module fmf_frontend_bench;
  import fmf_pkg::*;
  typedef struct packed {
    logic [31:0] addr;
    fmf_op_t     op;
    logic [1:0]  size;
    fmf_target_t target;
    logic [1:0]  bank;
    logic [4:0]  sector;
    logic        err;
  } fmf_row_t;
  localparam fmf_row_t ROWS [15] = '{
    '{32'h0000_0000, FMF_OP_READ,  2'h2, FMF_T_FLASH, 2'h0, 5'h00, 1'h0},
    '{32'h0001_8000, FMF_OP_ERASE, 2'h2, FMF_T_FLASH, 2'h0, 5'h03, 1'h0},
    '{32'h0001_A004, FMF_OP_ERASE, 2'h2, FMF_T_FLASH, 2'h0, 5'h04, 1'h1},
    '{32'h0001_FFFF, FMF_OP_READ,  2'h0, FMF_T_FLASH, 2'h0, 5'h05, 1'h0},
    '{32'h0006_0000, FMF_OP_READ,  2'h2, FMF_T_FLASH, 2'h0, 5'h09, 1'h0},
    '{32'h0008_0000, FMF_OP_READ,  2'h2, FMF_T_FLASH, 2'h1, 5'h0A, 1'h0},
    '{32'h0010_0000, FMF_OP_PROG,  2'h3, FMF_T_FLASH, 2'h2, 5'h0E, 1'h1},
    '{32'h0010_0002, FMF_OP_PROG,  2'h1, FMF_T_FLASH, 2'h2, 5'h0E, 1'h0},
    '{32'h001E_0000, FMF_OP_ERASE, 2'h2, FMF_T_FLASH, 2'h3, 5'h15, 1'h0},
    '{32'h0802_7FFC, FMF_OP_READ,  2'h2, FMF_T_RAM,   2'h0, 5'h00, 1'h0},
    '{32'h0802_8000, FMF_OP_READ,  2'h2, FMF_T_NONE,  2'h0, 5'h00, 1'h1},
    '{32'hFE00_0000, FMF_OP_READ,  2'h2, FMF_T_CHK,   2'h0, 5'h00, 1'h0},
    '{32'hFFF8_7FFC, FMF_OP_READ,  2'h2, FMF_T_FWR,   2'h0, 5'h00, 1'h0},
    '{32'hFFF8_8000, FMF_OP_READ,  2'h2, FMF_T_NONE,  2'h0, 5'h00, 1'h1},
    '{32'hFFFF_FF00, FMF_OP_READ,  2'h2, FMF_T_SYS,   2'h0, 5'h00, 1'h0}};
  localparam logic [127:0] L1 = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [127:0] L2 = 128'hA5A5_0F0F_3C3C_9696_5A5A_F0F0_C3C3_6969;
  logic         clock, sys_rst, req_valid, rsp_valid, cfg_we, cfg_ext16, ext16;
  logic         send, line_valid, line_ready, beat_valid, req_ready;
  logic [2:0]   cfg_read_ctl, rd_ctl;
  logic [127:0] send_line, line;
  logic [63:0]  beat_data;
  fmf_req_t     req;
  fmf_rsp_t     rsp, rsp_half;
  int           fail_count, num_checks;

  fmf_frontend u_dut (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .cfg_we(cfg_we),
    .cfg_read_ctl(cfg_read_ctl),
    .cfg_ext16(cfg_ext16), .flash_read_control_field(rd_ctl), .ext_width16(ext16),
    .flash_line_valid(line_valid), .flash_line(line), .flash_line_ready(line_ready),
    .beat_valid(beat_valid), .beat_data(beat_data));
  // Half flash, small RAM variant sees the same requests
  fmf_frontend #(.FULL_FLASH(1'b0), .BIG_RAM(1'b0)) u_half (.clock(clock), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .req_ready(), .rsp_valid(), .rsp(rsp_half),
    .cfg_we(cfg_we), .cfg_read_ctl(cfg_read_ctl), .cfg_ext16(cfg_ext16),
    .flash_read_control_field(), .ext_width16(), .flash_line_valid(1'b0), .flash_line('0),
    .flash_line_ready(), .beat_valid(), .beat_data());
  fmf_flash_model u_flash (.clock(clock), .sys_rst(sys_rst), .send(send), .send_line(send_line),
    .flash_line_ready(line_ready), .flash_line_valid(line_valid), .flash_line(line));

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    chk({rd_ctl, ext16, rsp_valid}, {3'h0, 1'h1, 1'h0});
  endtask : do_reset

  task automatic set_cfg(input logic [2:0] ctl, input logic e16);
    @(negedge clock);
    cfg_we = 1'b1;
    cfg_read_ctl = ctl;
    cfg_ext16 = e16;
    @(negedge clock);
    cfg_we = 1'b0;
    chk({rd_ctl, ext16}, {ctl, e16});
  endtask : set_cfg

  task automatic access(input logic [31:0] a);
    @(negedge clock);
    req_valid = 1'b1;
    req = '{a, FMF_OP_READ, 2'h2};
    @(negedge clock);
    req_valid = 1'b0;
    chk({rsp_valid, req_ready}, 2'h3);
  endtask : access

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Watchdog: a hang ends the run as a failure
  initial begin
    #200us;
    fail_count++;
    results();
  end

  initial begin
    {sys_rst, req_valid, cfg_we, cfg_read_ctl, cfg_ext16, send, send_line, req} = '0;
    do_reset();
    // ****************************************************
    // Table of decodes, issued back to back
    // ****************************************************
    for (int i = 0; i <= 15; i++) begin
      @(negedge clock);
      if (i > 0) begin
        chk({rsp_valid, rsp.target, rsp.err}, {1'h1, ROWS[i-1].target, ROWS[i-1].err});
        if (ROWS[i-1].target == FMF_T_FLASH) begin
          chk({rsp.bank, rsp.sector}, {ROWS[i-1].bank, ROWS[i-1].sector});
          // Ten sectors in bank 0, so later banks sit two places off a multiple of four
          chk(rsp.local_sector,
              ROWS[i-1].bank ? 2'(ROWS[i-1].sector + 5'h02) : ROWS[i-1].sector);
        end
      end
      req_valid = (i < 15);
      if (i < 15) req = '{ROWS[i].addr, ROWS[i].op, ROWS[i].size};
    end
    $display("decode table done");
    access(32'h6000_0010); // Overlay use presumes CPU error checking is off
    chk({rsp.target, rsp.chip_sel, rsp.xaddr}, {FMF_T_EXT, 2'h0, 32'h6000_0010});
    access(32'h69FF_FFFC);
    chk({rsp.chip_sel, rsp.err}, {2'h1, 1'h0});
    access(32'h6A00_0000);
    chk(rsp.err, 1'h1);
    set_cfg(3'h0, 1'h0);
    access(32'h6100_0000);
    chk(rsp.err, 1'h1);
    $display("external range done");
    access(32'h0010_0000);
    chk({rsp.err, rsp_half.err}, 2'b01);
    access(32'h0802_0000);
    chk({rsp.err, rsp_half.err}, 2'b01);
    $display("variants done");
    // ****************************************************
    // Pipelined lines back to back, then a plain line
    // ****************************************************
    set_cfg(3'h1, 1'h1);
    send = 1'b1;
    send_line = L1;
    @(negedge clock);
    send_line = L2;
    @(negedge clock);
    chk({beat_valid, line_ready, beat_data}, {2'b10, L1[63:0]});
    @(negedge clock);
    send = 1'b0;
    chk({beat_valid, line_ready, beat_data}, {2'b11, L1[127:64]});
    @(negedge clock);
    chk({beat_valid, beat_data}, {1'b1, L2[63:0]});
    set_cfg(3'h0, 1'h1);
    send = 1'b1;
    send_line = L2;
    @(negedge clock);
    send = 1'b0;
    @(negedge clock);
    chk({beat_valid, line_ready, beat_data}, {2'b11, L2[63:0]});
    @(negedge clock);
    chk(beat_valid, 1'h0);
    $display("flash beats done");
    set_cfg(3'h7, 1'h0);
    do_reset();
    $display("second reset done");
    results();
  end
endmodule : fmf_frontend_bench

// ### src/fmf_frontend.sv
// Flash and memory map front end: address decode, read mode and access checks
`timescale 1ns/1ps
module fmf_frontend #(
  parameter bit FULL_FLASH = 1'b1,
  parameter bit BIG_RAM    = 1'b1
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              req_valid,
  input  wire fmf_pkg::fmf_req_t req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output fmf_pkg::fmf_rsp_t      rsp,
  input  wire logic              cfg_we,
  input  wire logic [2:0]        cfg_read_ctl,
  input  wire logic              cfg_ext16,
  output logic      [2:0]        flash_read_control_field,
  output logic                   ext_width16,
  input  wire logic              flash_line_valid,
  input  wire logic [127:0]      flash_line,
  output logic                   flash_line_ready,
  output logic                   beat_valid,
  output logic      [63:0]       beat_data
);
  import fmf_pkg::*;

  // ***************************************************************
  // Configuration state
  // ***************************************************************
  logic [2:0] rdctl_q;
  logic       ext16_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdctl_q <= FMF_RDCTL_RST;
    end else if (cfg_we) begin
      rdctl_q <= cfg_read_ctl;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext16_q <= FMF_EXT16_RST;
    end else if (cfg_we) begin
      ext16_q <= cfg_ext16;
    end
  end

  assign flash_read_control_field = rdctl_q;
  assign ext_width16              = ext16_q;

  // ***************************************************************
  // Address decode
  // ***************************************************************
  logic [1:0]  bank;
  logic [3:0]  lsec;
  logic [4:0]  gsec;
  logic [31:0] flash_end;
  logic [31:0] ram_bytes;
  logic [31:0] cs_lim;
  logic [31:0] cs_off;
  fmf_rsp_t    dec;

  fmf_sector_dec u_sector_dec (
    .addr         (req.addr),
    .bank         (bank),
    .local_sector (lsec),
    .sector       (gsec)
  );

  assign flash_end = FULL_FLASH ? FMF_FLASH_END_FULL : FMF_FLASH_END_HALF;
  assign ram_bytes = BIG_RAM ? FMF_RAM_BYTES_BIG : FMF_RAM_BYTES_SMALL;
  assign cs_lim    = ext16_q ? FMF_CS_LIM_16 : FMF_CS_LIM_8;
  assign cs_off    = req.addr & (FMF_CS_BASE_STEP - 32'h1);

  // External memory is never assumed initialised; no retention logic exists here
  always_comb begin
    dec              = '0;
    dec.target       = FMF_T_NONE;
    dec.bank         = bank;
    dec.sector       = gsec;
    dec.local_sector = lsec;
    dec.xaddr        = req.addr;
    if (req.addr <= FMF_FLASH_END_FULL) begin
      dec.target = FMF_T_FLASH;
      if (req.addr > flash_end) begin
        dec.err = 1'b1;
      end else if (req.op == FMF_OP_PROG) begin
        dec.err = !(req.size == 2'h1 || req.size == 2'h2);
      end else if (req.op == FMF_OP_ERASE) begin
        // Erase address must name the first byte of a sector
        dec.err = (req.addr != sect_base(req.addr, bank));
      end
    end else if (req.addr >= FMF_RAM_BASE && req.addr < FMF_RAM_BASE + ram_bytes) begin
      dec.target = FMF_T_RAM;
    end else if (req.addr >= FMF_OVL_BASE && req.addr < FMF_OVL_BASE + FMF_OVL_BYTES) begin
      // Overlay window lands on the first chip select; error checking is software's job
      dec.target   = FMF_T_EXT;
      dec.chip_sel = 2'h0;
      dec.xaddr    = FMF_CS0_BASE + (req.addr - FMF_OVL_BASE);
    end else if (req.addr >= FMF_CS0_BASE + FMF_OVL_BYTES
                 && req.addr < FMF_CS0_BASE + {FMF_CS_BASE_STEP[29:0], 2'h0}) begin
      dec.target   = FMF_T_EXT;
      dec.chip_sel = 2'((req.addr - FMF_CS0_BASE) >> 27);
      dec.err      = (cs_off >= cs_lim);
    end else if (req.addr >= FMF_CHK_BASE && req.addr <= FMF_CHK_END) begin
      dec.target = FMF_T_CHK;
    end else if (req.addr >= FMF_FWR_BASE && req.addr <= FMF_FWR_END) begin
      dec.target = FMF_T_FWR;
    end else if (req.addr >= FMF_SYS_BASE) begin
      dec.target = FMF_T_SYS;
    end else begin
      dec.err = 1'b1;
    end
  end

  function automatic logic [31:0] sect_base(input logic [31:0] a, input logic [1:0] b);
    logic [31:0] r;
    r = a;
    if (b != 2'h0) begin
      r = {a[31:FMF_SECT128_SHIFT], 17'h0};
    end else if (a < FMF_B0_S1) begin
      r = 32'h0;
    end else if (a < FMF_B0_S2) begin
      r = FMF_B0_S1;
    end else if (a < FMF_B0_S3) begin
      r = FMF_B0_S2;
    end else if (a < FMF_B0_S4) begin
      r = FMF_B0_S3;
    end else if (a < FMF_B0_S5) begin
      r = FMF_B0_S4;
    end else if (a < FMF_B0_S6) begin
      r = FMF_B0_S5;
    end else if (a < FMF_B0_S7) begin
      r = FMF_B0_S6;
    end else if (a < FMF_B0_S8) begin
      r = FMF_B0_S7;
    end else if (a < FMF_B0_S9) begin
      r = FMF_B0_S8;
    end else begin
      r = FMF_B0_S9;
    end
    return r;
  endfunction : sect_base

  // ***************************************************************
  // Registered answer
  // ***************************************************************
  assign req_ready = 1'b1;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsp <= '0;
    end else if (req_valid) begin
      rsp <= dec;
    end
  end

  // ***************************************************************
  // Flash line splitter
  // ***************************************************************
  // Pipeline mode: one 128-bit line leaves as two 64-bit beats, low half first.
  // Non-pipeline mode passes only the low half, one beat per line.
  logic         second_q;
  logic [63:0]  upper_q;
  logic         pipe_on;

  assign pipe_on          = (rdctl_q != FMF_RDCTL_RST);
  assign flash_line_ready = !second_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      second_q  <= 1'b0;
      upper_q   <= 64'h0;
      beat_valid <= 1'b0;
      beat_data <= 64'h0;
    end else if (second_q) begin
      second_q   <= 1'b0;
      beat_valid <= 1'b1;
      beat_data  <= upper_q;
    end else if (flash_line_valid) begin
      second_q   <= pipe_on;
      upper_q    <= flash_line[127:64];
      beat_valid <= 1'b1;
      beat_data  <= flash_line[63:0];
    end else begin
      beat_valid <= 1'b0;
    end
  end

  // Clock ceiling per mode is software's duty; nothing here can check it

endmodule : fmf_frontend

// ### src/fmf_sector_dec.sv
// Flash bank and sector decoder
`timescale 1ns/1ps
module fmf_sector_dec (
  input  wire logic [31:0] addr,
  output logic      [1:0]  bank,
  output logic      [3:0]  local_sector,
  output logic      [4:0]  sector
);
  import fmf_pkg::*;

  // ***************************************************************
  // Decode
  // ***************************************************************
  always_comb begin
    bank = addr[20:19];
    if (addr[20:19] == 2'h0) begin
      if (addr < FMF_B0_S1) begin
        local_sector = 4'h0;
      end else if (addr < FMF_B0_S2) begin
        local_sector = 4'h1;
      end else if (addr < FMF_B0_S3) begin
        local_sector = 4'h2;
      end else if (addr < FMF_B0_S4) begin
        local_sector = 4'h3;
      end else if (addr < FMF_B0_S5) begin
        local_sector = 4'h4;
      end else if (addr < FMF_B0_S6) begin
        local_sector = 4'h5;
      end else if (addr < FMF_B0_S7) begin
        local_sector = 4'h6;
      end else if (addr < FMF_B0_S8) begin
        local_sector = 4'h7;
      end else if (addr < FMF_B0_S9) begin
        local_sector = 4'h8;
      end else begin
        local_sector = 4'h9;
      end
      sector = {1'b0, local_sector};
    end else begin
      local_sector = {2'h0, addr[FMF_SECT128_SHIFT+1:FMF_SECT128_SHIFT]};
      // Global index: ten sectors in bank 0, four in each later bank
      sector = 5'(5'h0A + {addr[20:19] - 2'h1, 2'h0} + {3'h0, local_sector[1:0]});
    end
  end

endmodule : fmf_sector_dec
